/* File: hdl/mcrc_consts.svh */
// Purpose: Named constants for the mode, clock and reset control block
// Assumes: 25 MHz system clock
// Notes:   Definitions only
`ifndef MCRC_CONSTS_SVH
`define MCRC_CONSTS_SVH
`define MCRC_SW_CYC        2'h2
`define MCRC_CLR_CYC       2'h2
`define MCRC_HAZ_MIN       3'h2
`define MCRC_HAZ_MAX       3'h4
`define MCRC_SRC_W         2
`define MCRC_SRC_IRC       2'h0
`define MCRC_SRC_XOSC      2'h1
`define MCRC_FLG_W         8
`define MCRC_DES_POR       0
`define MCRC_DES_CORE_LV   1
`define MCRC_DES_IO_LV     2
`define MCRC_FES_CHKSTOP   0
`define MCRC_FES_SAFE      1
`define MCRC_FES_SWRST     2
`define MCRC_MODE_W        3
`define MCRC_MODE_RUN      3'h0
`define MCRC_MODE_SAFE     3'h1
`define MCRC_MODE_STANDBY  3'h2
`define MCRC_MODE_HALT     3'h3
`define MCRC_MODE_STOP     3'h4
`define MCRC_PER_CGM       0
`define MCRC_PER_PCU       1
`endif

/* File: hdl/mcrc_pkg.sv */
// Purpose: Types for the mode, clock and reset control block
// Assumes: Constants header included
// Notes:   Types only
`include "mcrc_consts.svh"
package mcrc_pkg;
    typedef enum logic [2:0] {
        MCRC_SW_IDLE   = 3'h0,
        MCRC_SW_VERIFY = 3'h1,
        MCRC_SW_MOVE   = 3'h2,
        MCRC_SW_STALL  = 3'h3
    } mcrc_sw_t;
    typedef enum logic [1:0] {
        MCRC_LP_RUN   = 2'h0,
        MCRC_LP_ENTER = 2'h1,
        MCRC_LP_HANG  = 2'h2,
        MCRC_LP_LOW   = 2'h3
    } mcrc_lp_t;
endpackage

/* File: hdl/mcrc_if.sv */
// Purpose: Joins the control block and its software-side partner
// Assumes: One clock
// Notes:   No clocking block
`timescale 1ns/1ps
`include "mcrc_consts.svh"
interface mcrc_if;
    logic                      sw_req;
    logic [`MCRC_SRC_W-1:0]    sw_src;
    logic                      sw_pend;
    logic [`MCRC_SRC_W-1:0]    sys_src;
    logic                      clk_halted;
    logic                      mode_req;
    logic [`MCRC_MODE_W-1:0]   mode_tgt;
    logic [`MCRC_MODE_W-1:0]   mode_cur;
    logic                      mode_busy;
    logic                      safe_en;
    logic                      can_frz;
    logic                      per_acc;
    logic                      per_sel;
    logic                      per_wr;
    logic [7:0]                per_wdata;
    logic [7:0]                per_rdata;
    logic                      per_err;
    logic [1:0]                per_dis;
    logic                      clr_req;
    logic                      clr_fes;
    logic [`MCRC_FLG_W-1:0]    clr_mask;
    logic                      sw_rst;
    logic [`MCRC_FLG_W-1:0]    des;
    logic [`MCRC_FLG_W-1:0]    fes;
    logic [`MCRC_FLG_W-1:0]    wkup_stat;
    modport dev (input sw_req, sw_src, mode_req, mode_tgt, safe_en, can_frz, per_acc,
                 per_sel, per_wr, per_wdata, per_dis, clr_req, clr_fes, clr_mask, sw_rst,
                 output sw_pend, sys_src, clk_halted, mode_cur, mode_busy, per_rdata,
                 per_err, des, fes, wkup_stat);
    modport sw  (output sw_req, sw_src, mode_req, mode_tgt, safe_en, can_frz, per_acc,
                 per_sel, per_wr, per_wdata, per_dis, clr_req, clr_fes, clr_mask, sw_rst,
                 input sw_pend, sys_src, clk_halted, mode_cur, mode_busy, per_rdata,
                 per_err, des, fes, wkup_stat);
endinterface

/* File: hdl/mcrc_dev.sv */
// Purpose: Mode entry, clock switching and reset status as this silicon behaves
// Assumes: Inputs synchronous to clock_i; rst_i covers every reset source
// Notes:   Stalled switch and hang states reproduce the silicon faults
`timescale 1ns/1ps
`include "mcrc_consts.svh"
// Overview of operation
// - Verify target clock running before switching
// - Switch completes within two target cycles
// - Safe request kills oscillator, may stall
// - Any reset recovers a stalled switch
// - Software blocks safe during oscillator transitions
// - Disabled clock/power peripherals ignore accesses silently
// - Software keeps those peripherals enabled in run
// - Wakeup in early low-power entry with flash_lp_i set checkstops
// - Checkstop sets flag, wakeup status keeps its earlier value
// - Active CAN blocks low-power entry, hangs
// - Software freezes CAN before low-power request
// - Status flag clear takes two cycles
// - Reset during clear leaves flag set
// - Aborted clear does not affect later clears
// - Software reads status back before soft reset
// - Dipped ramp leaves power flags zero
// - No safe exit except to a low-power mode while cause active
module mcrc_dev (
    input  wire logic                     clock_i,
    input  wire logic                     rst_i,
    input  wire logic                     xosc_run_i,
    input  wire logic                     xosc_tick_i,
    input  wire logic                     ramp_dip_i,
    input  wire logic                     por_i,
    input  wire logic                     core_lv_i,
    input  wire logic                     io_lv_i,
    input  wire logic                     safe_cause_i,
    input  wire logic                     wakeup_i,
    input  wire logic [`MCRC_FLG_W-1:0]   wakeup_ch_i,
    input  wire logic                     flash_lp_i,
    input  wire logic                     can_en_i,
    output logic                          xosc_on_o,
    output logic                          checkstop_o,
    mcrc_if.dev                           bus
);
    mcrc_pkg::mcrc_sw_t sw_st_r;
    mcrc_pkg::mcrc_lp_t lp_st_r;
    logic [1:0]                  sw_cnt_r;
    logic [`MCRC_SRC_W-1:0]      sw_tgt_r;
    logic [`MCRC_SRC_W-1:0]      src_r;
    logic                        xosc_off_r;
    logic [2:0]                  lp_cnt_r;
    logic [`MCRC_MODE_W-1:0]     mode_r;
    logic [`MCRC_MODE_W-1:0]     tgt_r;
    logic [`MCRC_FLG_W-1:0]      des_r;
    logic [`MCRC_FLG_W-1:0]      fes_r;
    logic [`MCRC_FLG_W-1:0]      wk_r;
    logic [`MCRC_FLG_W-1:0]      clr_s1_r;
    logic [`MCRC_FLG_W-1:0]      clr_s2_r;
    logic                        clr_fes_s1_r;
    logic                        clr_fes_s2_r;
    logic                        chk_r;
    logic                        init_r;
    logic [7:0]                  per_reg_r [2];
    logic [7:0]                  rdata_r;
    logic                        safe_go;
    logic                        lp_tgt;
    logic                        acc_ok;

    function automatic logic is_lp(input logic [`MCRC_MODE_W-1:0] m);
        return (m == `MCRC_MODE_STANDBY) || (m == `MCRC_MODE_HALT) ||
               (m == `MCRC_MODE_STOP);
    endfunction

    assign safe_go   = bus.safe_en && safe_cause_i && mode_r != `MCRC_MODE_SAFE;
    assign lp_tgt    = bus.mode_req && is_lp(bus.mode_tgt);
    assign xosc_on_o = !xosc_off_r;

    // Safe entry switches the oscillator off at once; only reset restores it
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            xosc_off_r <= 1'b0;
        end else if (safe_go) begin
            xosc_off_r <= 1'b1;
        end
    end

    // Clock switch engine
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sw_st_r  <= mcrc_pkg::MCRC_SW_IDLE;
            sw_cnt_r <= 2'h0;
            sw_tgt_r <= `MCRC_SRC_IRC;
            src_r    <= `MCRC_SRC_IRC;
        end else begin
            unique case (sw_st_r)
                mcrc_pkg::MCRC_SW_IDLE: begin
                    if (bus.sw_req && bus.sw_src != src_r) begin
                        sw_tgt_r <= bus.sw_src;
                        sw_st_r  <= mcrc_pkg::MCRC_SW_VERIFY;
                    end
                end
                mcrc_pkg::MCRC_SW_VERIFY: begin
                    // Internal source always runs; crystal must report running
                    if (sw_tgt_r != `MCRC_SRC_XOSC || (xosc_run_i && !xosc_off_r)) begin
                        sw_cnt_r <= 2'h0;
                        sw_st_r  <= mcrc_pkg::MCRC_SW_MOVE;
                    end
                end
                mcrc_pkg::MCRC_SW_MOVE: begin
                    if (sw_tgt_r == `MCRC_SRC_XOSC && (xosc_off_r || !xosc_run_i)) begin
                        sw_st_r <= mcrc_pkg::MCRC_SW_STALL;
                    end else if (sw_tgt_r != `MCRC_SRC_XOSC || xosc_tick_i) begin
                        if (sw_cnt_r == `MCRC_SW_CYC - 2'h1) begin
                            src_r   <= sw_tgt_r;
                            sw_st_r <= mcrc_pkg::MCRC_SW_IDLE;
                        end else begin
                            sw_cnt_r <= sw_cnt_r + 2'h1;
                        end
                    end
                end
                mcrc_pkg::MCRC_SW_STALL: begin
                    sw_st_r <= mcrc_pkg::MCRC_SW_STALL;
                end
                default: begin
                    sw_st_r <= mcrc_pkg::MCRC_SW_IDLE;
                end
            endcase
        end
    end

    assign bus.sw_pend    = sw_st_r != mcrc_pkg::MCRC_SW_IDLE;
    assign bus.sys_src    = src_r;
    assign bus.clk_halted = sw_st_r == mcrc_pkg::MCRC_SW_STALL;

    // Mode entry and low-power sequencing
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            lp_st_r  <= mcrc_pkg::MCRC_LP_RUN;
            mode_r   <= `MCRC_MODE_RUN;
            tgt_r    <= `MCRC_MODE_RUN;
            lp_cnt_r <= 3'h0;
            chk_r    <= 1'b0;
        end else begin
            chk_r <= 1'b0;
            unique case (lp_st_r)
                mcrc_pkg::MCRC_LP_RUN: begin
                    if (safe_go) begin
                        mode_r <= `MCRC_MODE_SAFE;
                    end else if (lp_tgt) begin
                        tgt_r    <= bus.mode_tgt;
                        lp_cnt_r <= 3'h0;
                        if (can_en_i && !bus.can_frz) begin
                            lp_st_r <= mcrc_pkg::MCRC_LP_HANG;
                        end else begin
                            lp_st_r <= mcrc_pkg::MCRC_LP_ENTER;
                        end
                    end else if (bus.mode_req && mode_r == `MCRC_MODE_SAFE) begin
                        if (!safe_cause_i) begin
                            mode_r <= bus.mode_tgt;
                        end
                    end else if (bus.mode_req) begin
                        mode_r <= bus.mode_tgt;
                    end
                end
                mcrc_pkg::MCRC_LP_ENTER: begin
                    lp_cnt_r <= lp_cnt_r + 3'h1;
                    if (wakeup_i && flash_lp_i && lp_cnt_r < `MCRC_HAZ_MAX) begin
                        chk_r   <= 1'b1;
                        lp_st_r <= mcrc_pkg::MCRC_LP_RUN;
                    end else if (lp_cnt_r >= `MCRC_HAZ_MAX - 3'h1) begin
                        mode_r  <= tgt_r;
                        lp_st_r <= mcrc_pkg::MCRC_LP_LOW;
                    end
                end
                mcrc_pkg::MCRC_LP_HANG: begin
                    lp_st_r <= mcrc_pkg::MCRC_LP_HANG;
                end
                mcrc_pkg::MCRC_LP_LOW: begin
                    if (wakeup_i) begin
                        mode_r  <= `MCRC_MODE_RUN;
                        lp_st_r <= mcrc_pkg::MCRC_LP_RUN;
                    end
                end
            endcase
        end
    end

    assign checkstop_o   = chk_r;
    assign bus.mode_cur  = mode_r;
    assign bus.mode_busy = lp_st_r == mcrc_pkg::MCRC_LP_ENTER ||
                           lp_st_r == mcrc_pkg::MCRC_LP_HANG;

    // Wakeup channel record; the checkstop path never records it
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wk_r <= '0;
        end else if (lp_st_r == mcrc_pkg::MCRC_LP_LOW && wakeup_i) begin
            wk_r <= wk_r | wakeup_ch_i;
        end
    end
    assign bus.wkup_stat = wk_r;

    // Clear requests cross a two-stage synchroniser; reset drops any in flight
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            clr_s1_r     <= '0;
            clr_s2_r     <= '0;
            clr_fes_s1_r <= 1'b0;
            clr_fes_s2_r <= 1'b0;
        end else begin
            clr_s1_r     <= bus.clr_req ? bus.clr_mask : '0;
            clr_fes_s1_r <= bus.clr_fes;
            clr_s2_r     <= clr_s1_r;
            clr_fes_s2_r <= clr_fes_s1_r;
        end
    end

    // Status flags live across reset; only init_r marks the first cycle
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            init_r <= 1'b1;
        end else begin
            init_r <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (init_r) begin
            // Dipped ramp loses the power flags
            des_r[`MCRC_DES_POR]     <= (des_r[`MCRC_DES_POR] | por_i) & !ramp_dip_i;
            des_r[`MCRC_DES_CORE_LV] <= (des_r[`MCRC_DES_CORE_LV] | core_lv_i) & !ramp_dip_i;
            des_r[`MCRC_DES_IO_LV]   <= (des_r[`MCRC_DES_IO_LV] | io_lv_i) & !ramp_dip_i;
            des_r[`MCRC_FLG_W-1:`MCRC_DES_IO_LV+1] <= '0;
        end else if (!clr_fes_s2_r) begin
            des_r <= des_r & ~clr_s2_r;
        end
        if (init_r && por_i) begin
            fes_r <= '0;
        end else begin
            // Set wins over clear
            fes_r <= (fes_r & ~(clr_fes_s2_r ? clr_s2_r : '0))
                     | ({{(`MCRC_FLG_W-1){1'b0}}, chk_r} << `MCRC_FES_CHKSTOP)
                     | ({{(`MCRC_FLG_W-1){1'b0}}, safe_go} << `MCRC_FES_SAFE)
                     | ({{(`MCRC_FLG_W-1){1'b0}}, bus.sw_rst} << `MCRC_FES_SWRST);
        end
    end
    assign bus.des = des_r;
    assign bus.fes = fes_r;

    // Clock/power peripheral registers; disabled ones drop accesses silently
    assign acc_ok = !bus.per_dis[bus.per_sel];
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            per_reg_r[`MCRC_PER_CGM] <= 8'h00;
            per_reg_r[`MCRC_PER_PCU] <= 8'h00;
            rdata_r                  <= 8'h00;
        end else if (bus.per_acc && acc_ok) begin
            if (bus.per_wr) begin
                per_reg_r[bus.per_sel] <= bus.per_wdata;
            end else begin
                rdata_r <= per_reg_r[bus.per_sel];
            end
        end
    end
    assign bus.per_rdata = rdata_r;
    assign bus.per_err   = 1'b0;
endmodule

/* File: hdl/mcrc_host.sv */
// Purpose: Software-side partner issuing commands with the safe sequences
// Assumes: User commands are one-cycle pulses
// Notes:   Blocks unsafe orderings rather than reporting them
`timescale 1ns/1ps
`include "mcrc_consts.svh"
module mcrc_host (
    input  wire logic                     clock_i,
    input  wire logic                     rst_i,
    input  wire logic                     sw_go_i,
    input  wire logic [`MCRC_SRC_W-1:0]   sw_src_i,
    input  wire logic                     mode_go_i,
    input  wire logic [`MCRC_MODE_W-1:0]  mode_tgt_i,
    input  wire logic                     safe_en_i,
    input  wire logic                     per_go_i,
    input  wire logic                     per_sel_i,
    input  wire logic                     per_wr_i,
    input  wire logic [7:0]               per_wdata_i,
    input  wire logic [1:0]               per_dis_i,
    input  wire logic                     clr_go_i,
    input  wire logic                     clr_fes_i,
    input  wire logic [`MCRC_FLG_W-1:0]   clr_mask_i,
    input  wire logic                     srst_go_i,
    output logic                          srst_wait_o,
    output logic [`MCRC_FLG_W-1:0]        fes_o,
    mcrc_if.sw                            bus
);
    logic                    xosc_mode_r;
    logic                    srst_pend_r;
    logic                    lp_mode;
    logic [`MCRC_FLG_W-1:0]  clr_mask_r;
    logic                    clr_fes_r;
    logic                    clr_chk_r;
    logic [`MCRC_FLG_W-1:0]  fes_r;

    assign lp_mode = bus.mode_cur == `MCRC_MODE_STANDBY ||
                     bus.mode_cur == `MCRC_MODE_HALT || bus.mode_cur == `MCRC_MODE_STOP;

    // Transition to a crystal-clocked mode is tracked from switch request
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            xosc_mode_r <= 1'b0;
        end else if (sw_go_i && sw_src_i == `MCRC_SRC_XOSC) begin
            xosc_mode_r <= 1'b1;
        end else if (!bus.sw_pend && !bus.mode_busy) begin
            xosc_mode_r <= 1'b0;
        end
    end

    assign bus.safe_en   = safe_en_i && !xosc_mode_r && !bus.sw_pend;
    assign bus.sw_req    = sw_go_i;
    assign bus.sw_src    = sw_src_i;
    assign bus.mode_req  = mode_go_i;
    assign bus.mode_tgt  = mode_tgt_i;
    assign bus.can_frz   = 1'b1;
    assign bus.per_acc   = per_go_i;
    assign bus.per_sel   = per_sel_i;
    assign bus.per_wr    = per_wr_i;
    assign bus.per_wdata = per_wdata_i;
    assign bus.per_dis   = lp_mode ? per_dis_i : 2'h0;
    assign bus.clr_req   = clr_go_i;
    assign bus.clr_fes   = clr_fes_i;
    assign bus.clr_mask  = clr_mask_i;

    // Soft reset waits until a readback shows the clear done
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            clr_mask_r  <= '0;
            clr_fes_r   <= 1'b0;
            clr_chk_r   <= 1'b0;
            srst_pend_r <= 1'b0;
        end else begin
            if (clr_go_i) begin
                clr_mask_r <= clr_mask_i;
                clr_fes_r  <= clr_fes_i;
                clr_chk_r  <= 1'b1;
            end else if (clr_chk_r &&
                         ((clr_fes_r ? bus.fes : bus.des) & clr_mask_r) == '0) begin
                clr_chk_r <= 1'b0;
            end
            if (srst_go_i) begin
                srst_pend_r <= 1'b1;
            end else if (srst_pend_r && !clr_chk_r && !clr_go_i) begin
                srst_pend_r <= 1'b0;
            end
        end
    end
    assign bus.sw_rst  = srst_pend_r && !clr_chk_r && !clr_go_i;
    assign srst_wait_o = srst_pend_r;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            fes_r <= '0;
        end else begin
            fes_r <= bus.fes;
        end
    end
    assign fes_o = fes_r;
endmodule

/* File: tb/mcrc_checker.sv */
// Purpose: Assertions on the link between the two ends
// Assumes: One clock domain, reset async active high
// Notes:   Sees the interface signals only
`timescale 1ns/1ps
module mcrc_checker (
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic       sw_req,
    input  wire logic [1:0] sw_src,
    input  wire logic       sw_pend,
    input  wire logic [1:0] sys_src,
    input  wire logic       clk_halted,
    input  wire logic       per_acc,
    input  wire logic       per_sel,
    input  wire logic [1:0] per_dis,
    input  wire logic [7:0] per_rdata,
    input  wire logic       per_err,
    input  wire logic       clr_req,
    input  wire logic       clr_fes,
    input  wire logic [7:0] clr_mask,
    input  wire logic [7:0] fes,
    input  wire logic [7:0] wkup_stat
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // Mask kept so the clear can be followed after the request drops
    logic [7:0] mask_r;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            mask_r <= 8'h00;
        end else if (clr_req) begin
            mask_r <= clr_mask;
        end
    end
    sequence s_take;
        sw_req && !sw_pend && !clk_halted && sw_src != sys_src;
    endsequence
    sequence s_to_internal;
        sw_pend [*3] ##1 (!sw_pend && sys_src == 2'h0);
    endsequence
    a_take_goes_pending: assert property (s_take |=> sw_pend)
        else $error("switch request not reported pending");
    a_internal_three_edges: assert property (s_take and sw_src == 2'h0 |=> s_to_internal)
        else $error("switch to internal source late or early");
    a_source_held_pending: assert property ($changed(sys_src) |-> $past(sw_pend))
        else $error("system source moved without a pending switch");
    a_stall_sticks: assert property (clk_halted |=> clk_halted && $stable(sys_src))
        else $error("stalled switch left without reset");
    a_disabled_no_read: assert property (per_acc && per_dis[per_sel] |=> $stable(per_rdata))
        else $error("disabled peripheral returned data");
    a_never_abort: assert property (!per_err)
        else $error("peripheral access raised an error");
    a_clear_two_edges: assert property (clr_req && clr_fes && (fes & clr_mask) != 8'h00
        |=> ((fes & mask_r) != 8'h00) ##[1:2] ((fes & mask_r) == 8'h00))
        else $error("flag clear timing wrong");
    a_wake_status_kept: assert property ($rose(fes[0]) |-> $stable(wkup_stat))
        else $error("checkstop changed wakeup status");
endmodule

/* File: tb/mode_clock_reset_control_tb.sv */
// Purpose: Self-checking bench for both ends of the control link
// Assumes: 25 MHz clock, inputs driven on the falling edge
// Notes:   Host latency unknown, so waits are bounded polls
`timescale 1ns/1ps
`include "mcrc_consts.svh"
module mode_clock_reset_control_tb;
    logic       clock_i, rst_i, xosc_run, xosc_tick, tick_en, ramp_dip, por, core_lv;
    logic       io_lv, safe_cause, wakeup, flash_lp, can_en, sw_go, mode_go, safe_en, chkstop;
    logic       per_go, per_sel, per_wr, clr_go, clr_fes, srst_go, xosc_on, srst_wait;
    logic [1:0] sw_src, per_dis;
    logic [2:0] mode_tgt;
    logic [7:0] wakeup_ch, per_wdata, clr_mask, old;
    int         n_fail, total_checks;
    mcrc_if link ();
    mcrc_dev mcrc_dev_i (.clock_i(clock_i), .rst_i(rst_i), .xosc_run_i(xosc_run),
        .xosc_tick_i(xosc_tick), .ramp_dip_i(ramp_dip), .por_i(por), .core_lv_i(core_lv),
        .io_lv_i(io_lv), .safe_cause_i(safe_cause), .wakeup_i(wakeup),
        .wakeup_ch_i(wakeup_ch), .flash_lp_i(flash_lp), .can_en_i(can_en),
        .xosc_on_o(xosc_on), .checkstop_o(chkstop), .bus(link));
    mcrc_host mcrc_host_i (.clock_i(clock_i), .rst_i(rst_i), .sw_go_i(sw_go),
        .sw_src_i(sw_src), .mode_go_i(mode_go), .mode_tgt_i(mode_tgt), .safe_en_i(safe_en),
        .per_go_i(per_go), .per_sel_i(per_sel), .per_wr_i(per_wr), .per_wdata_i(per_wdata),
        .per_dis_i(per_dis), .clr_go_i(clr_go), .clr_fes_i(clr_fes), .clr_mask_i(clr_mask),
        .srst_go_i(srst_go), .srst_wait_o(srst_wait), .fes_o(), .bus(link));
    mcrc_checker mcrc_checker_i (.clock_i(clock_i), .rst_i(rst_i), .sw_req(link.sw_req),
        .sw_src(link.sw_src), .sw_pend(link.sw_pend), .sys_src(link.sys_src),
        .clk_halted(link.clk_halted), .per_acc(link.per_acc), .per_sel(link.per_sel),
        .per_dis(link.per_dis), .per_rdata(link.per_rdata), .per_err(link.per_err),
        .clr_req(link.clr_req), .clr_fes(link.clr_fes), .clr_mask(link.clr_mask),
        .fes(link.fes), .wkup_stat(link.wkup_stat));
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    // Crystal slower than the system clock: one tick every other cycle
    always @(negedge clock_i) xosc_tick <= tick_en & ~xosc_tick;
    task automatic final_report();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [7:0] probe(int id);
        case (id)
            0: return {7'h00, link.sw_pend};
            1: return {7'h00, link.clk_halted};
            2: return {5'h00, link.mode_cur};
            3: return link.fes;
            4: return {7'h00, link.mode_busy};
            default: return {7'h00, srst_wait};
        endcase
    endfunction
    task automatic await(int id, logic [7:0] v);
        int k;
        for (k = 0; k < 60 && probe(id) !== v; k++) @(negedge clock_i);
        if (probe(id) !== v) begin
            n_fail++;
            $display("ERROR wait %0d expected %h seen %h", id, v, probe(id));
            final_report();
        end
    endtask
    task automatic pulse(ref logic go);
        @(negedge clock_i);
        go = 1'b1;
        @(negedge clock_i);
        go = 1'b0;
    endtask
    task automatic do_reset(logic dip, logic p, int cyc);
        ramp_dip = dip;
        por = p;
        rst_i = 1'b1;
        repeat (cyc) @(negedge clock_i);
        rst_i = 1'b0;
        repeat (2) @(negedge clock_i);
        ramp_dip = 1'b0;
        por = 1'b0;
    endtask
    task automatic switch_to(logic [1:0] src);
        sw_src = src;
        pulse(sw_go);
        await(0, 8'h01);
        await(0, 8'h00);
        chk("sys_src", {6'h00, src}, {6'h00, link.sys_src});
    endtask
    task automatic t_power();
        core_lv = 1'b1;
        do_reset(1'b1, 1'b1, 10);
        chk("des dipped", 8'h00, link.des & 8'h07);
        chk("fes por", 8'h00, link.fes);
        core_lv = 1'b0;
        io_lv = 1'b1;
        do_reset(1'b0, 1'b1, 2);
        io_lv = 1'b0;
        chk("des flags", 8'h05, link.des & 8'h07);
    endtask
    task automatic t_switch();
        xosc_run = 1'b0;
        sw_src = `MCRC_SRC_XOSC;
        pulse(sw_go);
        await(0, 8'h01);
        repeat (6) @(negedge clock_i);
        chk("src before run", 8'h00, {6'h00, link.sys_src});
        chk("pending", 8'h01, {7'h00, link.sw_pend});
        xosc_run = 1'b1;
        tick_en = 1'b1;
        await(0, 8'h00);
        chk("src crystal", 8'h01, {6'h00, link.sys_src});
        switch_to(`MCRC_SRC_IRC);
    endtask
    task automatic t_stall();
        tick_en = 1'b0;
        sw_src = `MCRC_SRC_XOSC;
        pulse(sw_go);
        await(0, 8'h01);
        repeat (3) @(negedge clock_i);
        xosc_run = 1'b0;
        await(1, 8'h01);
        sw_src = `MCRC_SRC_IRC;
        pulse(sw_go);
        repeat (5) @(negedge clock_i);
        chk("still halted", 8'h01, {7'h00, link.clk_halted});
        do_reset(1'b0, 1'b0, 1);
        chk("halt cleared", 8'h00, {7'h00, link.clk_halted});
        xosc_run = 1'b1;
        tick_en = 1'b1;
        switch_to(`MCRC_SRC_XOSC);
        switch_to(`MCRC_SRC_IRC);
    endtask
    task automatic t_lowpower();
        can_en = 1'b1;
        mode_tgt = `MCRC_MODE_HALT;
        pulse(mode_go);
        await(2, 8'h03);
        per_dis = 2'h1;
        old = link.per_rdata;
        per_wr = 1'b1;
        pulse(per_go);
        per_wr = 1'b0;
        pulse(per_go);
        chk("rdata kept", old, link.per_rdata);
        chk("no error", 8'h00, {7'h00, link.per_err});
        per_dis = 2'h0;
        wakeup_ch = 8'h05;
        pulse(wakeup);
        await(2, 8'h00);
        chk("wake status", 8'h05, link.wkup_stat);
    endtask
    task automatic t_checkstop();
        flash_lp = 1'b1;
        mode_tgt = `MCRC_MODE_STOP;
        pulse(mode_go);
        await(4, 8'h01);
        wakeup_ch = 8'hA0;
        pulse(wakeup);
        chk("chkstop", 8'h01, {7'h00, chkstop});
        await(3, 8'h01);
        chk("wake status kept", 8'h05, link.wkup_stat);
        await(2, 8'h00);
        flash_lp = 1'b0;
    endtask
    task automatic t_clear();
        safe_en = 1'b1;
        safe_cause = 1'b1;
        await(2, 8'h01);
        await(3, 8'h03);
        chk("crystal off", 8'h00, {7'h00, xosc_on});
        clr_mask = 8'h02;
        mode_tgt = `MCRC_MODE_RUN;
        pulse(clr_go);
        repeat (6) @(negedge clock_i);
        pulse(mode_go);
        chk("safe held", 8'h01, {5'h00, link.mode_cur});
        safe_cause = 1'b0;
        safe_en = 1'b0;
        pulse(mode_go);
        await(2, 8'h00);
        clr_mask = 8'h01;
        pulse(clr_go);
        do_reset(1'b0, 1'b0, 1);
        chk("abort", 8'h01, link.fes);
        clr_mask = 8'h03;
        pulse(clr_go);
        await(3, 8'h00);
    endtask
    task automatic t_soft();
        pulse(srst_go);
        await(3, 8'h04);
        await(5, 8'h00);
        chk("soft flag", 8'h04, link.fes);
    endtask
    initial begin
        repeat (20000) @(posedge clock_i);
        n_fail++;
        $display("ERROR run limit expected 0 seen 1");
        final_report();
    end
    initial begin
        {rst_i, xosc_run, tick_en, ramp_dip, por, core_lv, io_lv, safe_cause} = 8'h80;
        {wakeup, flash_lp, can_en, sw_go, mode_go, safe_en, per_go, per_sel} = 8'h00;
        {per_wr, clr_go, srst_go} = 3'h0;
        clr_fes = 1'b1;
        sw_src = 2'h0;
        per_dis = 2'h0;
        mode_tgt = 3'h0;
        wakeup_ch = 8'h00;
        per_wdata = 8'h5A;
        clr_mask = 8'h00;
        n_fail = 0;
        total_checks = 0;
        @(negedge clock_i);
        t_power();
        t_switch();
        t_stall();
        t_lowpower();
        t_checkstop();
        t_clear();
        t_soft();
        final_report();
    end
endmodule
